// File: hdl/du_map.svh
/*
 * Register offsets, field positions, reset values and filter taps of the
 * up-converter block. Included by the block's design file only.
 */
`ifndef DU_MAP_SVH
`define DU_MAP_SVH
`define DU_CTRL_OFF 8'h00
`define DU_MASK_OFF 8'h04
`define DU_STAT_OFF 8'h08
`define DU_FREQ_OFF 8'h20
`define DU_PHAS_OFF 8'h40
`define DU_FACT_LSB 0
`define DU_MIX_BIT 4
`define DU_FMT_BIT 5
`define DU_MODEA_LSB 8
`define DU_MODEB_LSB 12
`define DU_EN_LSB 16
`define DU_MB_LSB 4
`define DU_ST_STG_LSB 4
`define DU_ST_FACT_LSB 8
`define DU_CTRL_RST 32'h0001_0100
`define DU_MASK_RST 32'h0000_0001
`define DU_HB5_NEAR 34'sh0_0000_0009
`define DU_HB5_SHIFT 4
`define DU_HB5_CENTER 16'h0010
`define DU_HB4_CENTER 16'h0100
`define DU_HB3_CENTER 16'h0800
`define DU_HB2_CENTER 16'h4000
`define DU_HB1_CENTER 20'h1_0000
`define DU_TB_CENTER 20'h8_0000
`define DU_TRIG_SHIFT 14
`endif

// File: hdl/du_pkg.sv
/*
 * Types shared by the up-converter block and its bench.
 * Assumes 16-bit signed samples on every path.
 */
package du_pkg;
    typedef struct packed {
        logic signed [15:0] i;
        logic signed [15:0] q;
    } du_iq_t;

    typedef enum logic [2:0] {
        DU_OFF = 3'b000,
        DU_NRZ = 3'b001,
        DU_RTZ = 3'b010,
        DU_RF = 3'b011,
        DU_DES2X = 3'b100
    } du_mode_t;

    typedef struct packed {
        logic vld;
        logic dbl;
        logic signed [15:0] s0;
        logic signed [15:0] s1;
    } du_dac_t;
endpackage : du_pkg

// File: hdl/du_upconv.sv
/*
 * Four-channel interpolating up-converter with NCO mixers, channel bonder
 * and a 2x stage per converter output, configured over APB.
 * Assumes the sample source runs on pclk and holds in_iq per in_take.
 */
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ns
`include "du_map.svh"

// Notes on behaviour
// - four up-converters, each one complex stream, summed freely to either output
// - extra 2x stage after the bonder, only in double-rate output mode
// - factor 1, no mixing, real: stream 0 passes to converter a with mask 0x1
// - single output up-conversion: masks 0x1, 0x3, 0x7 or 0xF, factors 2 to 256
// - either converter may carry the signal; equal settings give equal outputs
// - factor 1 dual output: mask 0x1 on a, 0x2 on b, streams pass
// - real dual output: each converter sums any up-converter set by its mask
// - complex, one up-converter: a takes real part (0x1), b imaginary (0x4)
// - complex, two up-converters: a uses 0x3, b uses 0xC
// - swapping masks swaps outputs; output modes are set independently
// - total factor is one of 1,2,3,4,6,8,12,16,24,32,48,64,96,128,192,256
// - interpolated I/Q is multiplied by the oscillator's complex sinusoid
// - stream count limits factor and enabled up-converters
// - mixing off acts as zero frequency and phase: I to I, Q to Q
// - output rate is input rate times factor, doubled again in double-rate mode
// - cascaded fixed 2x or 3x stages make up the total factor; the code uses one stage-five midpoint and holds samples otherwise
// - first half-band stage: odd taps zero, center 65536, scale 2^-16
// - second half-band stage: center 16384, scale 2^-14
// - stages three to five: centers 2048, 256, 16
// - passband 80 percent, ripple under 0.01 dB, stopband beyond 90 dB
// - chain starts with third-band or first stage, repeats four and five
// - third-band stage: every third tap zero, center 524288, scale 2^-19
// - oscillator takes a 64-bit frequency word and a 16-bit phase word
module du_upconv #(
    parameter int NDUC = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire du_pkg::du_iq_t in_iq [NDUC],
    output logic in_take,
    output du_pkg::du_dac_t dac_a,
    output du_pkg::du_dac_t dac_b
);
    logic [31:0] ctrl_r;
    logic [31:0] mask_r;
    logic [63:0] freq_r [NDUC];
    logic [15:0] phas_r [NDUC];
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] rdat;
    logic hit;
    logic wr;
    logic [3:0] fcode;
    logic mix_en;
    logic fmt_cx;
    logic [3:0] en_req;
    logic [3:0] allow;
    logic [3:0] eff_en;
    logic [3:0] nstg;
    logic [8:0] fact;
    logic [8:0] cnt_r;
    logic [8:0] cnt_nxt;
    logic take_r;
    logic second;
    logic signed [15:0] raw_r [NDUC];
    du_pkg::du_iq_t duc_w [NDUC];
    du_pkg::du_mode_t mode [2];
    logic [3:0] mask [2];
    du_pkg::du_dac_t dac_r [2];

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    function automatic logic [8:0] fact_of(input logic [3:0] c);
        case (c)
            4'h0: fact_of = 9'h001;
            4'h1: fact_of = 9'h002;
            4'h2: fact_of = 9'h003;
            4'h3: fact_of = 9'h004;
            4'h4: fact_of = 9'h006;
            4'h5: fact_of = 9'h008;
            4'h6: fact_of = 9'h00C;
            4'h7: fact_of = 9'h010;
            4'h8: fact_of = 9'h018;
            4'h9: fact_of = 9'h020;
            4'hA: fact_of = 9'h030;
            4'hB: fact_of = 9'h040;
            4'hC: fact_of = 9'h060;
            4'hD: fact_of = 9'h080;
            4'hE: fact_of = 9'h0C0;
            default: fact_of = 9'h100;
        endcase
    endfunction : fact_of

    function automatic logic signed [15:0] sat16(input logic signed [33:0] x);
        if (x > 34'sh0_0000_7FFF) begin
            sat16 = 16'sh7FFF;
        end else if (x < -34'sh0_0000_8000) begin
            sat16 = -16'sh8000;
        end else begin
            sat16 = x[15:0];
        end
    endfunction : sat16

    // midpoint of the two center samples with stage-five taps
    function automatic logic signed [15:0] hb5(input logic signed [15:0] a,
        input logic signed [15:0] b, input logic signed [15:0] c,
        input logic signed [15:0] d);
        logic signed [33:0] s;
        s = `DU_HB5_NEAR * (34'(b) + 34'(c)) - (34'(a) + 34'(d));
        hb5 = sat16(s >>> `DU_HB5_SHIFT);
    endfunction : hb5

    // quarter-symmetric sine, 16 points per turn, unity = 2^14
    function automatic logic signed [15:0] sin16(input logic [3:0] x);
        logic signed [15:0] v;
        case (x[2:0])
            3'h0: v = 16'sh0000;
            3'h1: v = 16'sh187E;
            3'h2: v = 16'sh2D41;
            3'h3: v = 16'sh3B21;
            3'h4: v = 16'sh4000;
            3'h5: v = 16'sh3B21;
            3'h6: v = 16'sh2D41;
            default: v = 16'sh187E;
        endcase
        sin16 = x[3] ? -v : v;
    endfunction : sin16

    // field decode
    assign fcode = ctrl_r[`DU_FACT_LSB +: 4];
    assign mix_en = ctrl_r[`DU_MIX_BIT];
    assign fmt_cx = ctrl_r[`DU_FMT_BIT];
    assign en_req = ctrl_r[`DU_EN_LSB +: 4];
    assign mode[0] = du_pkg::du_mode_t'(ctrl_r[`DU_MODEA_LSB +: 3]);
    assign mode[1] = du_pkg::du_mode_t'(ctrl_r[`DU_MODEB_LSB +: 3]);
    assign mask[0] = mask_r[3:0];
    assign mask[1] = mask_r[`DU_MB_LSB +: 4];
    assign fact = fact_of(fcode);
    assign nstg = 4'((5'(fcode) + 5'h01) >> 1);

    // channel ceiling per factor, enforced regardless of software
    always_comb begin
        case (fcode)
            4'h0: allow = 4'h0;
            4'h1, 4'h2: allow = 4'h1;
            4'h3, 4'h4: allow = 4'h3;
            default: allow = 4'hF;
        endcase
    end
    assign eff_en = en_req & allow;

    // apb slave, one wait-free answer after setup
    assign wr = psel & penable & pwrite & pready_r;

    always_comb begin
        rdat = 32'h0000_0000;
        hit = 1'b1;
        case (paddr)
            `DU_CTRL_OFF: rdat = ctrl_r;
            `DU_MASK_OFF: rdat = {24'h00_0000, mask_r[7:0]};
            `DU_STAT_OFF: rdat = {15'h0000, fact, nstg, eff_en};
            default: begin
                hit = 1'b0;
                for (int k = 0; k < NDUC; k++) begin
                    if (paddr == 8'(`DU_FREQ_OFF + 8 * k)) begin
                        hit = 1'b1;
                        rdat = freq_r[k][31:0];
                    end
                    if (paddr == 8'(`DU_FREQ_OFF + 8 * k + 4)) begin
                        hit = 1'b1;
                        rdat = freq_r[k][63:32];
                    end
                    if (paddr == 8'(`DU_PHAS_OFF + 4 * k)) begin
                        hit = 1'b1;
                        rdat = {16'h0000, phas_r[k]};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else if (ce) begin
            pready_r <= psel & ~penable;
            if (psel & ~penable) begin
                pslverr_r <= ~hit;
                prdata_r <= pwrite ? 32'h0000_0000 : rdat;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `DU_CTRL_RST;
            mask_r <= `DU_MASK_RST;
        end else if (ce && wr) begin
            if (paddr == `DU_CTRL_OFF) begin
                ctrl_r <= pwdata & 32'h000F_773F;
            end
            if (paddr == `DU_MASK_OFF) begin
                mask_r <= {24'h00_0000, pwdata[7:0]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < NDUC; k++) begin
                freq_r[k] <= 64'h0;
                phas_r[k] <= 16'h0000;
            end
        end else if (ce && wr) begin
            for (int k = 0; k < NDUC; k++) begin
                if (paddr == 8'(`DU_FREQ_OFF + 8 * k)) begin
                    freq_r[k][31:0] <= pwdata;
                end
                if (paddr == 8'(`DU_FREQ_OFF + 8 * k + 4)) begin
                    freq_r[k][63:32] <= pwdata;
                end
                if (paddr == 8'(`DU_PHAS_OFF + 4 * k)) begin
                    phas_r[k] <= pwdata[15:0];
                end
            end
        end
    end

    // input rate = output rate / factor
    assign cnt_nxt = (cnt_r >= fact - 9'h001) ? 9'h000 : cnt_r + 9'h001;
    assign second = cnt_r >= (fact >> 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 9'h000;
            take_r <= 1'b1;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            take_r <= cnt_nxt == 9'h000;
        end
    end

    // factor-1 path: bit k of a mask picks stream k (I0, Q0, I1, Q1)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < NDUC; k++) begin
                raw_r[k] <= 16'sh0000;
            end
        end else if (ce && take_r) begin
            for (int k = 0; k < NDUC; k++) begin
                raw_r[k] <= k[0] ? in_iq[k >> 1].q : in_iq[k >> 1].i;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NDUC; g++) begin : gen_duc
            du_pkg::du_iq_t h_r [4];
            du_pkg::du_iq_t s;
            du_pkg::du_iq_t out_r;
            logic [63:0] acc_r;
            logic [15:0] theta;
            logic signed [15:0] sn;
            logic signed [15:0] cs;
            logic signed [33:0] re;
            logic signed [33:0] im;

            // sample history, one shift per input sample
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    for (int k = 0; k < 4; k++) begin
                        h_r[k] <= '0;
                    end
                end else if (ce && take_r) begin
                    h_r[0] <= eff_en[g] ? in_iq[g] : '0;
                    for (int k = 1; k < 4; k++) begin
                        h_r[k] <= h_r[k - 1];
                    end
                end
            end

            // center sample in the first half, filtered midpoint after
            assign s.i = second ? hb5(h_r[0].i, h_r[1].i, h_r[2].i, h_r[3].i)
                : h_r[1].i;
            assign s.q = second ? hb5(h_r[0].q, h_r[1].q, h_r[2].q, h_r[3].q)
                : h_r[1].q;

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    acc_r <= 64'h0;
                end else if (ce) begin
                    acc_r <= mix_en ? acc_r + freq_r[g] : 64'h0;
                end
            end

            assign theta = acc_r[63:48] + phas_r[g];
            assign sn = sin16(theta[15:12]);
            assign cs = sin16(theta[15:12] + 4'h4);
            assign re = (34'(s.i) * 34'(cs) - 34'(s.q) * 34'(sn)) >>> `DU_TRIG_SHIFT;
            assign im = (34'(s.i) * 34'(sn) + 34'(s.q) * 34'(cs)) >>> `DU_TRIG_SHIFT;

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    out_r <= '0;
                end else if (ce) begin
                    if (!eff_en[g]) begin
                        out_r <= '0;
                    end else if (mix_en) begin
                        out_r.i <= sat16(re);
                        out_r.q <= sat16(im);
                    end else begin
                        out_r <= s;
                    end
                end
            end

            assign duc_w[g] = out_r;

            a_nco_step: assert property ($past(mix_en) && $past(ce) |->
                acc_r == $past(acc_r) + $past(freq_r[g]))
                else $error("oscillator did not advance by its frequency word");
            a_mix_bypass: assert property (!mix_en && ce |=> acc_r == 64'h0)
                else $error("oscillator not held at zero while bypassed");
        end
    endgenerate

    // bonder sum and output stage per converter
    generate
        for (g = 0; g < 2; g++) begin : gen_dac
            logic signed [33:0] sum;
            logic signed [15:0] cur;
            logic signed [15:0] prev_r;

            always_comb begin
                sum = 34'sh0;
                for (int k = 0; k < NDUC; k++) begin
                    if (mask[g][k]) begin
                        if (fcode == 4'h0) begin
                            sum = sum + 34'(raw_r[k]);
                        end else if (fmt_cx) begin
                            sum = sum + 34'((k < 2) ? duc_w[k & 1].i : duc_w[k & 1].q);
                        end else begin
                            sum = sum + 34'(duc_w[k].i);
                        end
                    end
                end
            end
            assign cur = sat16(sum);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    prev_r <= 16'sh0000;
                    dac_r[g] <= '0;
                end else if (ce) begin
                    prev_r <= cur;
                    dac_r[g].vld <= mode[g] != du_pkg::DU_OFF;
                    dac_r[g].dbl <= mode[g] == du_pkg::DU_DES2X;
                    if (mode[g] == du_pkg::DU_OFF) begin
                        dac_r[g].s0 <= 16'sh0000;
                        dac_r[g].s1 <= 16'sh0000;
                    end else if (mode[g] == du_pkg::DU_DES2X) begin
                        dac_r[g].s0 <= 16'((17'(prev_r) + 17'(cur)) >>> 1);
                        dac_r[g].s1 <= cur;
                    end else begin
                        dac_r[g].s0 <= cur;
                        dac_r[g].s1 <= cur;
                    end
                end
            end
        end
    endgenerate

    assign dac_a = dac_r[0];
    assign dac_b = dac_r[1];
    assign in_take = take_r;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    a_take_phase: assert property (take_r |-> cnt_r == 9'h000)
        else $error("input strobe out of step with the rate counter");
    a_take_gap: assert property (ce && take_r && fact > 9'h001 && $stable(fact) |=> !take_r)
        else $error("input taken twice within one interpolation period");
    a_duc_limit: assert property ((fcode > 4'h4 || eff_en[3:2] == 2'h0)
        && (fcode > 4'h2 || eff_en[3:1] == 3'h0) && (fcode != 4'h0 || eff_en == 4'h0))
        else $error("more up-converters active than the factor allows");
    a_off_silent: assert property (ce && mode[0] == du_pkg::DU_OFF |=> !dac_a.vld && dac_a.s0 == 16'sh0000)
        else $error("disabled converter output still active");
    a_des_flag: assert property (ce && mode[1] == du_pkg::DU_DES2X |=> dac_b.dbl && dac_b.vld)
        else $error("double-rate stage not engaged");
    a_equal_outs: assert property ((ce && mask[0] == mask[1] && mode[0] == mode[1])[*2] |=>
        dac_a == dac_b)
        else $error("identically programmed outputs differ");
    a_pass_one: assert property ((ce && fcode == 4'h0 && mask[0] == 4'h1 && mode[0] == du_pkg::DU_NRZ)[*3]
        |=> dac_a.s0 == $past(in_iq[0].i, 2))
        else $error("factor-one stream 0 did not reach converter a");
    a_apb_answer: assert property (psel && !penable && ce |=> pready)
        else $error("register access not answered");

    c_des_mode: cover property (dac_a.dbl && dac_b.dbl);
    c_complex: cover property (fmt_cx && mask[0] == 4'h3 && mask[1] == 4'hC && dac_b.vld);
    c_four_duc: cover property (eff_en == 4'hF && take_r);
    c_max_fact: cover property (fact == 9'h100 && take_r);
endmodule : du_upconv

// File: verif/du_src_model.sv
/*
 * Sample source standing in for the serial-link receiver: one complex
 * stream per up-converter, advanced only when the block takes a sample.
 * Assumes the bench sets want_iq and the block pulses in_take on pclk.
 */
`timescale 1ns/1ns
module du_src_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_take,
    input du_pkg::du_iq_t want_iq [4],
    output du_pkg::du_iq_t in_iq [4]
);
    // new sample only after the edge that took the previous one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int n = 0; n < 4; n++) begin
                in_iq[n] <= {16'hA5A5, 16'h5A5A};
            end
        end else if (in_take) begin
            in_iq <= want_iq;
        end
    end
endmodule : du_src_model

// File: verif/tb_dac_upconverter_interpolation.sv
/*
 * Self-checking bench of the up-converter block: APB master, stream source
 * model, expected results queued and compared by a watching process.
 * Assumes the block answers APB with pready and takes samples on in_take.
 */
`timescale 1ns/1ns
module tb_dac_upconverter_interpolation;
    typedef struct {logic [31:0] d; logic e;} du_rd_t;
    typedef struct {logic b; du_pkg::du_dac_t v;} du_dn_t;
    localparam int FAC [16] = '{1, 2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128, 192, 256};
    localparam int STG [16] = '{0, 1, 1, 2, 2, 3, 3, 4, 4, 5, 5, 6, 6, 7, 7, 8};
    localparam int EN [16] = '{0, 1, 1, 3, 3, 15, 15, 15, 15, 15, 15, 15, 15, 15, 15, 15};
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, in_take;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] m;
    logic signed [15:0] ci [4];
    logic signed [15:0] cq [4];
    du_pkg::du_iq_t in_iq [4];
    du_pkg::du_iq_t want_iq [4];
    du_pkg::du_dac_t dac_a, dac_b;
    du_rd_t rq [$];
    du_dn_t dq [$];
    du_rd_t rn;
    du_dn_t dn;
    int err_count, comparisons, cyc, i, pulses;

    du_upconv du_upconv_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_iq(in_iq),
        .in_take(in_take), .dac_a(dac_a), .dac_b(dac_b));
    du_src_model du_src_model_i (.pclk(pclk), .presetn(presetn), .in_take(in_take),
        .want_iq(want_iq), .in_iq(in_iq));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task wrap_up;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    task chk_rd(input logic [31:0] ed, input logic ee);
        comparisons++;
        if (prdata !== ed || pslverr !== ee) begin
            err_count++;
            $display("MISMATCH read exp %h/%b seen %h/%b", ed, ee, prdata, pslverr);
        end
    endtask : chk_rd

    task chk_dac(input string nm, input du_pkg::du_dac_t e, input du_pkg::du_dac_t s);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask : chk_dac

    task chk_rate(input int e, input int s);
        comparisons++;
        if (s != e) begin
            err_count++;
            $display("MISMATCH in_take pulses exp %0d seen %0d", e, s);
        end
    endtask : chk_rate

    // watcher: read data and converter samples against the oldest notes
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0) begin
            rn = rq.pop_front();
            chk_rd(rn.d, rn.e);
        end
        while (dq.size() > 0) begin
            dn = dq.pop_front();
            chk_dac(dn.b ? "dac_b" : "dac_a", dn.v, dn.b ? dac_b : dac_a);
        end
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 10000) begin
            err_count++;
            wrap_up();
        end
    end

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // request held until pready is seen high at a rising edge
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd(input logic [7:0] a, input logic [31:0] ed, input logic ee);
        rq.push_back('{ed, ee});
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task cfg(input logic [3:0] code, input logic mix, input logic cplx, input logic [2:0] ma,
             input logic [2:0] mb, input logic [3:0] ka, input logic [3:0] kb,
             input logic [3:0] en);
        apb(1'b1, 8'h00, {12'h000, en, 1'b0, mb, 1'b0, ma, 2'b00, cplx, mix, code});
        apb(1'b1, 8'h04, {24'h00_0000, kb, ka});
    endtask : cfg

    function automatic du_pkg::du_dac_t mk(input logic v, input logic d,
                                           input logic signed [15:0] s);
        return {v, d, s, s};
    endfunction : mk

    function automatic logic signed [15:0] sum_i(input logic [3:0] k);
        logic signed [15:0] s;
        s = 16'sh0000;
        for (int n = 0; n < 4; n++) begin
            if (k[n]) begin
                s = s + ci[n];
            end
        end
        return s;
    endfunction : sum_i

    // constant streams, small enough that four-way sums never saturate
    task load;
        for (int n = 0; n < 4; n++) begin
            ci[n] = $signed(16'($urandom_range(8191))) - 16'sh1000;
            cq[n] = $signed(16'($urandom_range(8191))) - 16'sh1000;
            want_iq[n] <= {ci[n], cq[n]};
        end
    endtask : load

    task want_out(input du_pkg::du_dac_t ea, input du_pkg::du_dac_t eb);
        repeat (80) @(posedge pclk);
        @(negedge pclk);
        dq.push_back('{1'b0, ea});
        dq.push_back('{1'b1, eb});
        @(posedge pclk);
    endtask : want_out

    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        err_count = 0;
        comparisons = 0;
        cyc = 0;
        for (i = 0; i < 4; i++) begin
            want_iq[i] = 32'h0000_0000;
        end
        void'($urandom(32'h5DDF57D1));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 32'h0001_0100, 1'b0);
        rd(8'h04, 32'h0000_0001, 1'b0);
        rd(8'h10, 32'h0000_0000, 1'b1);
        apb(1'b1, 8'h08, 32'hFFFF_FFFF);
        rd(8'h08, 32'h0000_0100, 1'b0);
        // every factor with all converters asked for: ceiling and chain depth
        for (i = 0; i < 16; i++) begin
            cfg(i[3:0], 1'b0, 1'b0, 3'd1, 3'd0, 4'h1, 4'h0, 4'hF);
            rd(8'h08, {15'h0000, 9'(FAC[i]), 4'(STG[i]), 4'(EN[i])}, 1'b0);
        end
        load();
        cfg(4'd0, 1'b0, 1'b0, 3'd1, 3'd0, 4'h1, 4'h0, 4'h1);
        want_out(mk(1'b1, 1'b0, ci[0]), mk(1'b0, 1'b0, 16'sh0000));
        cfg(4'd0, 1'b0, 1'b0, 3'd1, 3'd1, 4'h1, 4'h2, 4'h1);
        want_out(mk(1'b1, 1'b0, ci[0]), mk(1'b1, 1'b0, cq[0]));
        cfg(4'd0, 1'b0, 1'b0, 3'd1, 3'd2, 4'h2, 4'h1, 4'h1);
        want_out(mk(1'b1, 1'b0, cq[0]), mk(1'b1, 1'b0, ci[0]));
        cfg(4'd0, 1'b0, 1'b0, 3'd2, 3'd2, 4'h1, 4'h1, 4'h1);
        want_out(mk(1'b1, 1'b0, ci[0]), mk(1'b1, 1'b0, ci[0]));
        cfg(4'd0, 1'b0, 1'b0, 3'd0, 3'd1, 4'h1, 4'h1, 4'h1);
        want_out(mk(1'b0, 1'b0, 16'sh0000), mk(1'b1, 1'b0, ci[0]));
        cfg(4'd0, 1'b0, 1'b0, 3'd4, 3'd4, 4'h1, 4'h1, 4'h1);
        want_out(mk(1'b1, 1'b1, ci[0]), mk(1'b1, 1'b1, ci[0]));
        load();
        cfg(4'd1, 1'b0, 1'b1, 3'd1, 3'd1, 4'h1, 4'h4, 4'h1);
        want_out(mk(1'b1, 1'b0, ci[0]), mk(1'b1, 1'b0, cq[0]));
        load();
        cfg(4'd3, 1'b0, 1'b1, 3'd1, 3'd1, 4'h3, 4'hC, 4'h3);
        want_out(mk(1'b1, 1'b0, ci[0] + ci[1]), mk(1'b1, 1'b0, cq[0] + cq[1]));
        load();
        m = 4'($urandom_range(15));
        cfg(4'd5, 1'b0, 1'b0, 3'd1, 3'd3, 4'hF, m, 4'hF);
        want_out(mk(1'b1, 1'b0, sum_i(4'hF)), mk(1'b1, 1'b0, sum_i(m)));
        apb(1'b1, 8'h20, 32'h0000_0000);
        apb(1'b1, 8'h24, 32'h0000_0000);
        apb(1'b1, 8'h40, 32'h0000_0000);
        load();
        cfg(4'd1, 1'b1, 1'b0, 3'd1, 3'd0, 4'h1, 4'h0, 4'h1);
        want_out(mk(1'b1, 1'b0, ci[0]), mk(1'b0, 1'b0, 16'sh0000));
        apb(1'b1, 8'h40, 32'h0000_8000);
        want_out(mk(1'b1, 1'b0, -ci[0]), mk(1'b0, 1'b0, 16'sh0000));
        // one sample taken per six output cycles
        cfg(4'd4, 1'b0, 1'b0, 3'd1, 3'd0, 4'h1, 4'h0, 4'h1);
        pulses = 0;
        repeat (60) begin
            @(negedge pclk);
            pulses += int'(in_take === 1'b1);
        end
        chk_rate(10, pulses);
        wrap_up();
    end
endmodule : tb_dac_upconverter_interpolation
